/* File: rtl/sram_exchange_pkg.sv */
// How it works
// (RQ1) Pass-through enable bit starts and reports mode
// (RQ2) Guard plus authentication blocks unauthenticated reader
// (RQ3) Data moves through 64-byte volatile buffer
// (RQ4) Pass-through buffer sits at sector 0 end
// (RQ5) Same access procedure in both directions
// (RQ6) Session direction set only by wired host
// (RQ7) No memory lock while buffer fills
// (RQ8) Host enables pass-through only with both supplies
// (RQ9) Losing either supply clears pass-through
// (RQ10) Bulk write fills whole buffer at once
// (RQ11) Window base 01h maps pages 04h-13h
// (RQ12) Mirror mode NAKs reserved pages and sectors
// (RQ13) Pass-through buffer at pages F0h-FFh
// (RQ14) Terminator page access hands buffer over
// (RQ15) Window enable maps buffer at base page
// (RQ16) Window and pass-through never both active
// (RQ17) Large variant sector 1 is user memory
package sram_exchange_pkg;
   localparam int       ADDR_W        = 8;
   localparam int       SRAM_WORDS    = 16;
   localparam int       SRAM_BITS     = SRAM_WORDS * 32;
   localparam bit [7:0] REG_CONFIG    = 8'h00;
   localparam bit [7:0] REG_SESSION   = 8'h04;
   localparam bit [7:0] REG_STATUS    = 8'h08;
   localparam bit [7:0] REG_PROT      = 8'h0c;
   localparam bit [1:0] REG_SRAM_SEL  = 2'h1;
   localparam int       CFG_FLOW_BIT  = 0;
   localparam int       CFG_GUARD_BIT = 1;
   localparam int       CFG_AUTH_BIT  = 2;
   localparam int       CFG_BASE_LSB  = 8;
   localparam int       SES_PT_BIT    = 0;
   localparam int       SES_FLOW_BIT  = 1;
   localparam int       SES_WIN_BIT   = 2;
   localparam int       STAT_OWN_BIT  = 0;
   localparam int       STAT_FLD_BIT  = 1;
   localparam int       STAT_WRD_BIT  = 2;
   localparam int       STAT_PT_BIT   = 3;
   localparam bit [31:0] CFG_RESET    = 32'h0000_0101;
   localparam bit [7:0] PROT_RESET    = 8'hff;
   localparam bit [7:0] PT_FIRST      = 8'hf0;
   localparam bit [7:0] TERM_PAGE     = 8'hff;
   localparam bit [7:0] NAK_A_FIRST   = 8'hea;
   localparam bit [7:0] NAK_A_LAST    = 8'heb;
   localparam bit [7:0] NAK_B_FIRST   = 8'hee;
   localparam bit [7:0] SES3_FIRST    = 8'hf8;
   localparam bit [7:0] SES3_LAST     = 8'hf9;
   localparam bit [8:0] WIN_SPAN      = 9'h00f;
   localparam bit [3:0] LAST_WORD     = 4'hf;

   typedef enum logic { OWN_RF = 1'b0, OWN_WIRED = 1'b1 } owner_t;
   typedef enum logic [1:0] {
      ANS_NONE = 2'b00, ANS_ACK = 2'b01, ANS_NAK = 2'b10, ANS_FWD = 2'b11
   } ans_t;
   typedef enum logic { LINK_IDLE = 1'b0, LINK_WAIT = 1'b1 } link_phase_t;

   typedef struct packed {
      logic                 bulk;
      logic                 write;
      logic                 authOk;
      logic [1:0]           sector;
      logic [7:0]           page;
      logic [SRAM_BITS-1:0] data;
   } rf_req_t;

   typedef struct packed {
      ans_t        code;
      logic [31:0] data;
   } rf_ans_t;

   typedef struct packed {
      logic [SRAM_WORDS-1:0][31:0] sram;
      logic [31:0]                 cfg;
      logic                        ptEn;
      logic                        flowSes;
      logic                        winEn;
      logic [7:0]                  protStart;
      owner_t                      owner;
      logic [1:0]                  fieldSync;
      logic [1:0]                  wiredSync;
      logic [2:0]                  reqSync;
      logic                        ansTog;
      rf_ans_t                     ans;
      logic [31:0]                 rdata;
   } ref_state_t;

   typedef struct packed {
      link_phase_t phase;
      logic        busy;
      logic        reqTog;
      rf_req_t     req;
      logic [2:0]  ansSync;
      logic        ansValid;
      rf_ans_t     ans;
   } link_state_t;
endpackage

/* File: rtl/sram_exchange.sv */
`timescale 1ns/1ps
module sram_exchange import sram_exchange_pkg::*; #(
   parameter bit LARGE_CAPACITY = 1'b1
) (
   input  wire logic              ref_clk,
   input  wire logic              rst,
   input  wire logic [ADDR_W-1:0] regAddr,
   input  wire logic [31:0]       regWdata,
   input  wire logic              regWrite,
   input  wire logic              regRead,
   output logic [31:0]            regRdata,
   input  wire logic              fieldPresent,
   input  wire logic              wiredPowerPresent,
   output logic                   passthroughActive,
   output owner_t                 bufferOwner,
   input  wire logic              nfcClk,
   input  wire logic              nfcRst,
   input  wire logic              rfReqValid,
   input  wire rf_req_t           rfReq,
   output logic                   rfBusy,
   output logic                   rfAnsValid,
   output rf_ans_t                rfAns
);
   // ************************************************************
   // Shared pass-through access procedure
   // ************************************************************
   // The side that owns the buffer writes when data flows away from it
   // and reads when data flows toward it; the same test serves both ends.
   function automatic logic ptAllowed(input logic isWrite, input logic rfToWired,
                                      input owner_t owner, input owner_t side);
      logic fromSide;
      fromSide = ((side == OWN_RF) == rfToWired);
      ptAllowed = (owner == side) && (isWrite == fromSide); // RQ5
   endfunction

   ref_state_t  r;
   ref_state_t  rNext;
   link_state_t l;
   link_state_t lNext;

   logic        powerOk;
   logic        reqEvent;
   logic        guardBlock;
   logic        mirrorMap;
   logic        ptHit;
   logic        winHit;
   logic        sramHit;
   logic        nakZone;
   logic        protBlock;
   logic        accessOk;
   logic [7:0]  winFirst;
   logic [8:0]  winLast;
   logic [7:0]  pageOff;
   logic [3:0]  idx;
   logic [3:0]  hostIdx;
   logic        hostSram;
   rf_req_t     req;

   // ************************************************************
   // Request decode against the page map
   // ************************************************************
   always_comb begin
      req        = l.req;
      powerOk    = r.fieldSync[1] & r.wiredSync[1];
      reqEvent   = r.reqSync[2] ^ r.reqSync[1];
      winFirst   = {r.cfg[CFG_BASE_LSB +: 6], 2'b00}; // RQ15
      winLast    = {1'b0, winFirst} + WIN_SPAN;
      ptHit      = r.ptEn && (req.sector == 2'd0) && (req.page >= PT_FIRST); // RQ4 RQ13
      winHit     = r.winEn && (req.sector == 2'd0) && (req.page >= winFirst)
                   && ({1'b0, req.page} <= winLast); // RQ11 RQ15
      sramHit    = ptHit || winHit;
      pageOff    = ptHit ? (req.page - PT_FIRST) : (req.page - winFirst);
      idx        = pageOff[3:0];
      mirrorMap  = r.ptEn || r.winEn;
      guardBlock = r.cfg[CFG_GUARD_BIT] && r.cfg[CFG_AUTH_BIT] && !req.authOk; // RQ2
      // Reserved pages and sectors answer NAK while either mapping is on
      nakZone    = mirrorMap && (
                   (req.sector == 2'd2) ||
                   ((req.sector == 2'd3) && (req.page != SES3_FIRST)
                    && (req.page != SES3_LAST)) ||
                   ((req.sector == 2'd1) && !LARGE_CAPACITY) ||
                   ((req.sector == 2'd0) && (req.page >= NAK_A_FIRST)
                    && (req.page <= NAK_A_LAST)) ||
                   ((req.sector == 2'd0) && (req.page >= NAK_B_FIRST))); // RQ12
      // A window placed over protected pages keeps their write protection
      protBlock  = winHit && req.write && (req.page >= r.protStart)
                   && !req.authOk;
      if (ptHit) begin
         accessOk = ptAllowed(req.write, r.flowSes, r.owner, OWN_RF); // RQ5
      end else begin
         accessOk = 1'b1; // RQ7
      end
      hostSram   = (regAddr[7:6] == REG_SRAM_SEL);
      hostIdx    = regAddr[5:2];
   end

   // ************************************************************
   // Register side, buffer and mode control
   // ************************************************************
   always_comb begin
      rNext           = r;
      rNext.fieldSync = {r.fieldSync[0], fieldPresent};
      rNext.wiredSync = {r.wiredSync[0], wiredPowerPresent};
      rNext.reqSync   = {r.reqSync[1:0], l.reqTog};
      rNext.rdata     = 32'h0;

      if (regWrite) begin
         if (regAddr == REG_CONFIG) begin
            rNext.cfg = regWdata;
         end else if (regAddr == REG_SESSION) begin
            // Only the wired side reaches this register; the reader has no path
            rNext.flowSes = regWdata[SES_FLOW_BIT]; // RQ6
            rNext.ptEn    = regWdata[SES_PT_BIT] && powerOk; // RQ1 RQ8
            rNext.winEn   = regWdata[SES_WIN_BIT] && !rNext.ptEn; // RQ16
            if (rNext.ptEn && !r.ptEn) begin
               rNext.owner = regWdata[SES_FLOW_BIT] ? OWN_RF : OWN_WIRED;
            end
         end else if (regAddr == REG_PROT) begin
            rNext.protStart = regWdata[7:0];
         end else if (hostSram) begin
            if (!r.ptEn) begin
               rNext.sram[hostIdx] = regWdata; // RQ3
            end else if (ptAllowed(1'b1, r.flowSes, r.owner, OWN_WIRED)) begin
               rNext.sram[hostIdx] = regWdata;
               if (hostIdx == LAST_WORD) begin
                  rNext.owner = OWN_RF; // RQ14
               end
            end
         end
      end

      if (regRead) begin
         if (regAddr == REG_CONFIG) begin
            rNext.rdata = r.cfg;
         end else if (regAddr == REG_SESSION) begin
            rNext.rdata = {29'h0, r.winEn, r.flowSes, r.ptEn}; // RQ1
         end else if (regAddr == REG_STATUS) begin
            rNext.rdata = {28'h0, r.ptEn, r.wiredSync[1], r.fieldSync[1], r.owner};
         end else if (regAddr == REG_PROT) begin
            rNext.rdata = {24'h0, r.protStart};
         end else if (hostSram) begin
            if (!r.ptEn) begin
               rNext.rdata = r.sram[hostIdx];
            end else if (ptAllowed(1'b0, r.flowSes, r.owner, OWN_WIRED)) begin
               rNext.rdata = r.sram[hostIdx]; // RQ5
               if (hostIdx == LAST_WORD) begin
                  rNext.owner = OWN_RF; // RQ14
               end
            end
         end
      end

      // The reader side wins a same-cycle collision on a buffer word
      if (reqEvent) begin
         rNext.ansTog   = ~r.ansTog;
         rNext.ans.data = 32'h0;
         if (sramHit) begin
            if (guardBlock || protBlock || !accessOk) begin
               rNext.ans.code = ANS_NAK; // RQ2
            end else if (req.bulk) begin
               // Whole buffer written in one transaction, only from its first page
               if (req.write && (idx == 4'h0)) begin
                  rNext.sram     = req.data; // RQ10
                  rNext.ans.code = ANS_ACK;
                  if (ptHit) begin
                     rNext.owner = OWN_WIRED; // RQ14
                  end
               end else begin
                  rNext.ans.code = ANS_NAK;
               end
            end else begin
               rNext.ans.code = ANS_ACK;
               if (req.write) begin
                  rNext.sram[idx] = req.data[31:0]; // RQ3
               end else begin
                  rNext.ans.data = r.sram[idx];
               end
               if (ptHit && (req.page == TERM_PAGE)) begin
                  rNext.owner = OWN_WIRED; // RQ14
               end
            end
         end else if (nakZone) begin
            rNext.ans.code = ANS_NAK; // RQ12
         end else begin
            // Sector 1 of the large part and all other pages go to the
            // non-volatile store, which applies its own protection
            rNext.ans.code = ANS_FWD; // RQ17
         end
      end

      if (r.ptEn && !powerOk) begin
         rNext.ptEn = 1'b0; // RQ9
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         r           <= '0;
         r.cfg       <= CFG_RESET;
         r.flowSes   <= CFG_RESET[CFG_FLOW_BIT];
         r.protStart <= PROT_RESET;
      end else begin
         r <= rNext;
      end
   end

   assign regRdata          = r.rdata;
   assign passthroughActive = r.ptEn;
   assign bufferOwner       = r.owner;

   // ************************************************************
   // Link side: request toggle out, answer toggle back
   // ************************************************************
   // The link clock must keep running until the answer returns, since
   // the answer edge is seen only through this domain's synchroniser.
   always_comb begin
      lNext          = l;
      lNext.ansSync  = {l.ansSync[1:0], r.ansTog};
      lNext.ansValid = 1'b0;
      case (l.phase)
         LINK_IDLE: begin
            if (rfReqValid) begin
               lNext.req    = rfReq;
               lNext.reqTog = ~l.reqTog;
               lNext.phase  = LINK_WAIT;
            end
         end
         LINK_WAIT: begin
            if (l.ansSync[2] ^ l.ansSync[1]) begin
               lNext.ans      = r.ans;
               lNext.ansValid = 1'b1;
               lNext.phase    = LINK_IDLE;
            end
         end
         default: lNext.phase = LINK_IDLE;
      endcase
      lNext.busy = (lNext.phase == LINK_WAIT);
   end

   always_ff @(posedge nfcClk) begin
      if (nfcRst) begin
         l <= '0;
      end else begin
         l <= lNext;
      end
   end

   assign rfBusy     = l.busy;
   assign rfAnsValid = l.ansValid;
   assign rfAns      = l.ans;

   // ************************************************************
   // Checks
   // ************************************************************
   sequence linkTaken;
      rfReqValid && (l.phase == LINK_IDLE);
   endsequence

   sequence linkAnswered;
      rfBusy ##[1:12] rfAnsValid;
   endsequence

   link_answer_a: assert property (@(posedge nfcClk) disable iff (nfcRst) // RQ5
      linkTaken |=> linkAnswered)
      else $error("link request not answered in time");

   pt_power_a: assert property (@(posedge ref_clk) disable iff (rst) // RQ8
      $rose(r.ptEn) |-> $past(r.fieldSync[1]) && $past(r.wiredSync[1]))
      else $error("pass-through started without both supplies");

   pt_drop_a: assert property (@(posedge ref_clk) disable iff (rst) // RQ9
      (r.ptEn && !powerOk && !regWrite) |=> !r.ptEn)
      else $error("pass-through kept after supply loss");

   map_exclusive_a: assert property (@(posedge ref_clk) disable iff (rst) // RQ16
      !(r.ptEn && r.winEn))
      else $error("window and pass-through both active");

   session_read_a: assert property (@(posedge ref_clk) disable iff (rst) // RQ1
      (regRead && (regAddr == REG_SESSION)) |=> (regRdata[SES_PT_BIT] == $past(r.ptEn)))
      else $error("session read does not show pass-through state");

   sector_nak_a: assert property (@(posedge ref_clk) disable iff (rst) // RQ12
      (reqEvent && mirrorMap && (req.sector == 2'd2)) |=> (r.ans.code == ANS_NAK))
      else $error("sector 2 access not refused");

   term_handoff_a: assert property (@(posedge ref_clk) disable iff (rst) // RQ14
      (reqEvent && ptHit && !req.bulk && (req.page == TERM_PAGE) && accessOk
       && !guardBlock) |=> (r.owner == OWN_WIRED) && (r.ans.code == ANS_ACK))
      else $error("terminator page did not hand over the buffer");

   guard_nak_a: assert property (@(posedge ref_clk) disable iff (rst) // RQ2
      (reqEvent && sramHit && guardBlock) |=> (r.ans.code == ANS_NAK))
      else $error("guarded buffer reached without authentication");

   window_read_a: assert property (@(posedge ref_clk) disable iff (rst) // RQ11
      (reqEvent && r.winEn && (r.cfg[CFG_BASE_LSB +: 6] == 6'h01) && (req.sector == 2'd0)
       && (req.page == 8'h13) && !req.write && !guardBlock && !regWrite)
      |=> (r.ans.data == $past(r.sram[15])) && (r.ans.code == ANS_ACK))
      else $error("window page 13h did not return last buffer word");

   bulk_fill_a: assert property (@(posedge ref_clk) disable iff (rst) // RQ10
      (reqEvent && ptHit && req.bulk && req.write && (idx == 4'h0) && accessOk && !guardBlock)
      |=> (r.sram == $past(req.data)))
      else $error("bulk write did not fill the buffer");

   // ************************************************************
   // Checks on the register and link contract
   // ************************************************************
   ans_pulse_a: assert property (@(posedge nfcClk) disable iff (nfcRst) // RQ5
      rfAnsValid |=> !rfAnsValid)
      else $error("link answer strobe longer than one cycle");

   read_idle_a: assert property (@(posedge ref_clk) disable iff (rst) // RQ3
      !regRead |=> (regRdata == 32'h0))
      else $error("read data present without a read");

   // At enable the owner is set by the write that turns pass-through on
   pt_owner_a: assert property (@(posedge ref_clk) disable iff (rst) // RQ6
      $rose(r.ptEn)
      |-> (r.owner == ($past(regWdata[SES_FLOW_BIT]) ? OWN_RF : OWN_WIRED)))
      else $error("owner does not follow flow at enable");

   flow_hold_a: assert property (@(posedge ref_clk) disable iff (rst) // RQ6
      !(regWrite && (regAddr == REG_SESSION)) |=> $stable(r.flowSes))
      else $error("flow changed without a session write");

   no_lock_a: assert property (@(posedge ref_clk) disable iff (rst) // RQ7
      (regWrite && (regAddr == REG_PROT)) |=> (r.protStart == $past(regWdata[7:0])))
      else $error("register write lost");

   wired_handoff_a: assert property (@(posedge ref_clk) disable iff (rst) // RQ14
      (regWrite && hostSram && (hostIdx == LAST_WORD) && r.ptEn && !r.flowSes
       && (r.owner == OWN_WIRED) && !reqEvent) |=> (r.owner == OWN_RF))
      else $error("last wired word did not hand over the buffer");

   pt_write_a: assert property (@(posedge ref_clk) disable iff (rst) // RQ13
      (reqEvent && ptHit && req.write && !req.bulk && accessOk && !guardBlock)
      |=> (r.sram[$past(idx)] == $past(req.data[31:0])))
      else $error("pass-through page write did not land");

   nak_page_a: assert property (@(posedge ref_clk) disable iff (rst) // RQ12
      (reqEvent && mirrorMap && !sramHit && (req.sector == 2'd0)
       && (req.page >= NAK_A_FIRST) && (req.page <= NAK_A_LAST)) |=> (r.ans.code == ANS_NAK))
      else $error("reserved sector 0 page not refused");
endmodule // sram_exchange

/* File: testbench/nfc_reader_model.sv */
`timescale 1ns/1ps
module nfc_reader_model import sram_exchange_pkg::*; (
   input  wire logic    rstIn,
   output logic         nfcClk,
   output logic         nfcRst,
   output logic         rfReqValid,
   output rf_req_t      rfReq,
   input  wire logic    rfBusy,
   input  wire logic    rfAnsValid,
   input  wire rf_ans_t rfAns
);
   logic run;
   logic busyAtTake = 1'b0;
   logic inFrame = 1'b0;
   // Field clock stands still between frames, so the link logic only ever sees framed traffic
   assign run = rstIn | nfcRst | inFrame;
   initial begin
      nfcClk = 1'b0;
      #37;
      forever begin
         #80;
         if (run || nfcClk) begin
            nfcClk = ~nfcClk;
         end
      end
   end
   initial begin
      nfcRst = 1'b1;
      rfReqValid = 1'b0;
      rfReq = '0;
   end
   always @(posedge nfcClk) begin
      nfcRst <= rstIn;
   end
   // ****************************************************
   // One request outstanding; slow adds idle field cycles
   // ****************************************************
   task automatic xfer(input rf_req_t r, input int slow, output rf_ans_t a);
      int n;
      n = 0;
      busyAtTake = 1'b0;
      inFrame = 1'b1;
      repeat (2 + slow) @(posedge nfcClk);
      rfReqValid <= 1'b1;
      rfReq      <= r;
      @(posedge nfcClk);
      rfReqValid <= 1'b0;
      // Released request lines carry garbage, never the last value
      rfReq      <= ~r;
      do begin
         @(posedge nfcClk);
         #1;
         n++;
         if (n == 1) begin
            busyAtTake = rfBusy;
         end
      end while (rfAnsValid !== 1'b1 && n < 16);
      a = rfAns;
      if (rfAnsValid !== 1'b1) begin
         a.code = ANS_NONE;
      end
      inFrame = 1'b0;
   endtask
endmodule // nfc_reader_model

/* File: testbench/dual_port_sram_passthrough_map_tb.sv */
`timescale 1ns/1ps
module dual_port_sram_passthrough_map_tb import sram_exchange_pkg::*;;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  regAddr = '0;
   logic [31:0] regWdata = '0;
   logic        regWrite = 1'b0;
   logic        regRead = 1'b0;
   logic        fieldPresent = 1'b0;
   logic        wiredPowerPresent = 1'b1;
   logic [31:0] regRdata, rdAns;
   logic        passthroughActive, nfcClk, nfcRst, rfReqValid, rfBusy, rfAnsValid;
   owner_t      bufferOwner;
   rf_req_t     rfReq, bq;
   rf_ans_t     rfAns;
   logic [31:0] bufWords [16];
   logic [9:0]  cornerTbl [16] = '{10'h0ea, 10'h0eb, 10'h0ee, 10'h0ff, 10'h0ec, 10'h0e9,
      10'h303, 10'h3f8, 10'h3f9, 10'h3fa, 10'h204, 10'h150, 10'h004, 10'h013, 10'h014, 10'h003};
   int          errCount = 0;
   int          testsRun = 0;
   int          seed = 32'hd93f;
   always #50 ref_clk = ~ref_clk;
   sram_exchange #(.LARGE_CAPACITY(1'b1)) dut_u (.ref_clk(ref_clk), .rst(rst),
      .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
      .regRdata(regRdata), .fieldPresent(fieldPresent), .wiredPowerPresent(wiredPowerPresent),
      .passthroughActive(passthroughActive), .bufferOwner(bufferOwner), .nfcClk(nfcClk),
      .nfcRst(nfcRst), .rfReqValid(rfReqValid), .rfReq(rfReq), .rfBusy(rfBusy),
      .rfAnsValid(rfAnsValid), .rfAns(rfAns));
   nfc_reader_model rdr_u (.rstIn(rst), .nfcClk(nfcClk), .nfcRst(nfcRst),
      .rfReqValid(rfReqValid), .rfReq(rfReq), .rfBusy(rfBusy), .rfAnsValid(rfAnsValid),
      .rfAns(rfAns));
   // **********************
   // Shared tasks, models
   // **********************
   task automatic close_out;
      if (errCount == 0 && testsRun > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      testsRun++;
      if (got !== exp) begin
         errCount++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic regWr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      regWrite <= 1'b1;
      regAddr  <= a;
      regWdata <= d;
      @(posedge ref_clk);
      regWrite <= 1'b0;
   endtask
   task automatic regRd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                        input string what);
      @(posedge ref_clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge ref_clk);
      regRead <= 1'b0;
      #1;
      chk(what, e, regRdata & m);
   endtask
   function automatic rf_req_t mk(input logic [1:0] s, input logic [7:0] p, input logic w,
                                  input logic au, input logic [31:0] d);
      mk = '0;
      mk.sector = s;
      mk.page = p;
      mk.write = w;
      mk.authOk = au;
      mk.data[31:0] = d;
   endfunction
   task automatic rf(input rf_req_t r, input ans_t ec, input string what);
      rf_ans_t a;
      rdr_u.xfer(r, $random(seed) & 3, a);
      chk(what, {30'h0, ec}, {30'h0, a.code});
      chk("rfBusy", 32'h1, {31'h0, rdr_u.busyAtTake});
      chk("rfBusy after answer", 32'h0, {31'h0, rfBusy});
      rdAns = a.data;
   endtask
   // Window mapping with base block 1
   function automatic ans_t mapCode(input logic [1:0] s, input logic [7:0] p);
      if (s == 2'h0 && p >= 8'h04 && p <= 8'h13) return ANS_ACK;
      if (s == 2'h0 && (p inside {[8'hea:8'heb], [8'hee:8'hff]})) return ANS_NAK;
      if (s == 2'h2 || (s == 2'h3 && !(p inside {8'hf8, 8'hf9}))) return ANS_NAK;
      return ANS_FWD;
   endfunction
   task automatic ownerIs(input owner_t o);
      repeat (3) @(posedge ref_clk);
      #1;
      chk("bufferOwner", {31'h0, o}, {31'h0, bufferOwner});
   endtask
   task automatic wiredReadAll;
      for (int i = 0; i < 16; i++) begin
         regRd(8'h40 + 8'(4 * i), '1, bufWords[i], "wired buffer read");
      end
   endtask
   initial begin
      #5ms;
      errCount++;
      close_out();
   end
   // **********************
   // Main sequence
   // **********************
   initial begin
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (3) @(posedge ref_clk);
      regRd(REG_CONFIG, '1, CFG_RESET, "config reset");
      regRd(REG_PROT, '1, {24'h0, PROT_RESET}, "prot reset");
      regRd(REG_STATUS, '1, 32'h4, "status reset");
      regRd(8'h30, '1, 32'h0, "unmapped");
      regWr(REG_SESSION, 32'h4);
      foreach (cornerTbl[k]) begin
         rf(mk(cornerTbl[k][9:8], cornerTbl[k][7:0], 1'b0, 1'b1, 0),
            mapCode(cornerTbl[k][9:8], cornerTbl[k][7:0]), "window map");
      end
      for (int k = 0; k < 24; k++) begin
         bq = mk(2'($random(seed)), 8'($random(seed)), 1'($random(seed)), 1'b1, $random(seed));
         rf(bq, mapCode(bq.sector, bq.page), "window random");
      end
      bufWords[0] = $random(seed);
      rf(mk(2'h0, 8'h13, 1'b1, 1'b1, bufWords[0]), ANS_ACK, "window write");
      rf(mk(2'h0, 8'h13, 1'b0, 1'b1, 0), ANS_ACK, "window read");
      chk("window data", bufWords[0], rdAns);
      regWr(REG_PROT, 32'h10);
      rf(mk(2'h0, 8'h12, 1'b1, 1'b0, 0), ANS_NAK, "window protected");
      rf(mk(2'h0, 8'h0f, 1'b1, 1'b0, 0), ANS_ACK, "window unprotected");
      regWr(REG_PROT, {24'h0, PROT_RESET});
      regWr(REG_SESSION, 32'h3);
      regRd(REG_SESSION, 32'h1, 32'h0, "enable without field");
      @(posedge ref_clk);
      fieldPresent <= 1'b1;
      repeat (4) @(posedge ref_clk);
      regWr(REG_SESSION, 32'h7);
      regRd(REG_SESSION, 32'h5, 32'h1, "pt wins over window");
      chk("passthroughActive", 32'h1, {31'h0, passthroughActive});
      ownerIs(OWN_RF);
      rf(mk(2'h0, 8'hf0, 1'b0, 1'b0, 0), ANS_NAK, "rf read wrong dir");
      regRd(8'h40, '1, 32'h0, "wired read not owner");
      for (int i = 0; i < 16; i++) begin
         bufWords[i] = $random(seed);
         rf(mk(2'h0, 8'hf0 + 8'(i), 1'b1, 1'b0, bufWords[i]), ANS_ACK, "rf write");
      end
      ownerIs(OWN_WIRED);
      wiredReadAll();
      ownerIs(OWN_RF);
      regWr(REG_SESSION, 32'h0);
      regWr(REG_SESSION, 32'h1);
      ownerIs(OWN_WIRED);
      rf(mk(2'h0, 8'hf0, 1'b1, 1'b0, 0), ANS_NAK, "rf write wrong dir");
      for (int i = 0; i < 16; i++) begin
         bufWords[i] = $random(seed);
         regWr(8'h40 + 8'(4 * i), bufWords[i]);
      end
      ownerIs(OWN_RF);
      for (int i = 0; i < 16; i++) begin
         rf(mk(2'h0, 8'hf0 + 8'(i), 1'b0, 1'b0, 0), ANS_ACK, "rf read");
         chk("rf data", bufWords[i], rdAns);
      end
      ownerIs(OWN_WIRED);
      regWr(REG_SESSION, 32'h0);
      regWr(REG_SESSION, 32'h3);
      bq = mk(2'h0, 8'hf1, 1'b1, 1'b0, 0);
      bq.bulk = 1'b1;
      rf(bq, ANS_NAK, "bulk off start");
      for (int i = 0; i < 16; i++) begin
         bufWords[i] = $random(seed);
         bq.data[32 * i +: 32] = bufWords[i];
      end
      bq.page = PT_FIRST;
      rf(bq, ANS_ACK, "bulk write");
      ownerIs(OWN_WIRED);
      wiredReadAll();
      regWr(REG_CONFIG, 32'h0000_0107);
      rf(mk(2'h0, 8'hf0, 1'b1, 1'b0, 0), ANS_NAK, "guard no auth");
      rf(mk(2'h0, 8'hf0, 1'b1, 1'b1, 0), ANS_ACK, "guard auth");
      @(posedge ref_clk);
      fieldPresent <= 1'b0;
      repeat (6) @(posedge ref_clk);
      #1;
      chk("pt after supply loss", 32'h0, {31'h0, passthroughActive});
      regRd(REG_SESSION, 32'h1, 32'h0, "session after loss");
      rf(mk(2'h0, 8'hf0, 1'b1, 1'b1, 0), ANS_FWD, "unmapped after loss");
      @(posedge ref_clk);
      fieldPresent <= 1'b1;
      repeat (4) @(posedge ref_clk);
      regWr(REG_SESSION, 32'h1);
      #1;
      chk("pt with both supplies", 32'h1, {31'h0, passthroughActive});
      @(posedge ref_clk);
      wiredPowerPresent <= 1'b0;
      repeat (6) @(posedge ref_clk);
      #1;
      chk("pt after wired loss", 32'h0, {31'h0, passthroughActive});
      regWr(REG_SESSION, 32'h1);
      regRd(REG_SESSION, 32'h1, 32'h0, "enable without wired");
      regRd(REG_STATUS, 32'he, 32'h2, "status after wired loss");
      close_out();
   end
endmodule // dual_port_sram_passthrough_map_tb
